/* File: verilog/osr_pkg.sv */
`default_nettype none

package osr_pkg;

  // ----------------------------------------------------------------
  // internal register map (10-bit address: page in [9:8])
  // ----------------------------------------------------------------
  localparam logic [9:0] A_IDENT = 10'h000;
  localparam logic [9:0] A_CTRL = 10'h007;
  localparam logic [9:0] A_OE = 10'h011;
  localparam logic [9:0] A_HS_LO = 10'h017;
  localparam logic [9:0] A_HS_HI = 10'h018;
  localparam logic [9:0] A_FB0 = 10'h01A;
  localparam logic [9:0] A_FB1 = 10'h01B;
  localparam logic [9:0] A_FB2 = 10'h01C;
  localparam logic [9:0] A_FB3 = 10'h01D;
  localparam logic [9:0] A_FB4 = 10'h01E;
  localparam logic [9:0] A_FB5 = 10'h01F;
  localparam logic [9:0] A_CAL = 10'h045;
  localparam logic [9:0] A_FFO0 = 10'h0E7;
  localparam logic [9:0] A_FFO1 = 10'h0E8;
  localparam logic [9:0] A_FFO2 = 10'h0E9;
  localparam logic [7:0] PTR_PAGE = 8'hFF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RST_BIT = 7;
  localparam int CTRL_CAL_BIT = 3;
  localparam int OE_BIT = 0;
  localparam int LSD_LSB = 4;
  localparam int CAL_SKIP_BIT = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_OE = 1'b1;
  localparam logic [10:0] RST_HS = 11'h054;
  localparam logic [2:0] RST_LSD = 3'h0;
  localparam logic [42:0] RST_FB = 43'h064_0000_0000;
  localparam logic RST_SKIP = 1'b0;
  localparam logic [7:0] CAL_RSVD_RD = 8'h01;
  localparam logic [23:0] RST_FFO = 24'h00_0000;
  localparam logic [1:0] RST_PAGE = 2'h0;

  // ----------------------------------------------------------------
  // divider limits
  // ----------------------------------------------------------------
  localparam logic [10:0] HS_MIN = 11'h005;
  localparam logic [10:0] HS_ODD_MAX = 11'h021;
  localparam logic [10:0] HS_MAX = 11'h7FE;
  localparam logic [10:0] FB_INT_MIN = 11'h03C;
  localparam logic [10:0] FB_INT_MAX = 11'h7FD;
  localparam logic [2:0] LSD_MAX_CODE = 3'h5;
  localparam logic [5:0] RATIO_MAX = 6'h20;

  // ----------------------------------------------------------------
  // serial side
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h55;

endpackage : osr_pkg

`default_nettype wire

/* File: verilog/osr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - register 0 reads a fixed 8-bit type code; writes do nothing
// - writing 1 to reset bit of register 7 resets device; bit self-clears
// - writing 1 to trigger bit of register 7 starts calibration; bit self-clears
// - override 0 in register 17 disables output; 1 hands control to enable pin
// - high-speed divider is 11 bits over 23/24; 5..33 any, up to 2046 even
// - power-of-two code 0..5 divides 1..32; codes 6 and 7 also give 32
// - feedback divider is 43 bits over 26..31, 11 integer and 32 fraction bits
// - calibration skip bit in register 69 set means calibration is not run
// - fine offset is 24-bit two's complement, 0.0001164 ppm per step
// - fine offset takes effect only when register 233 is written
// - 2-bit page in register 255 forms address bits 9:8

module osr_regs #(
  parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary value
  parameter logic [6:0] SLAVE_ADDR = osr_pkg::SLAVE_ADDR_DEF
) (
  // core clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // serial link
  input wire logic link_clock_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // enable pin
  input wire logic active_low_enable_pin_n_in,
  // control towards synthesizer and output driver
  output logic clock_output_enable_out,
  output logic device_reset_out,
  output logic calibration_start_out,
  output logic [10:0] high_speed_divider_out,
  output logic high_speed_divider_valid_out,
  output logic [2:0] power_of_two_divider_out,
  output logic [5:0] power_of_two_ratio_out,
  output logic [42:0] feedback_divider_out,
  output logic feedback_integer_valid_out,
  output logic [23:0] fine_frequency_offset_out,
  output logic fine_offset_update_out
);

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    LS_IDLE = 8'h01,
    LS_ADDR = 8'h02,
    LS_AACK = 8'h04,
    LS_RX = 8'h08,
    LS_RXACK = 8'h10,
    LS_RDREQ = 8'h20,
    LS_TX = 8'h40,
    LS_TXACK = 8'h80
  } osr_lstate_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_d;
    logic sda_d;
    osr_lstate_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] rbyte;
    logic [7:0] ptr;
    logic rw;
    logic first_byte;
    logic req_tgl;
    logic req_we;
    logic [7:0] req_ptr;
    logic [7:0] req_wd;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic sda_drv;
    logic scl_hold;
  } osr_link_t;

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [1:0] page;
    logic oe_ovr;
    logic [10:0] hs;
    logic [2:0] lsd;
    logic [42:0] fb;
    logic skip;
    logic [15:0] ffo_stage;
    logic [23:0] ffo;
    logic ffo_upd;
    logic dev_rst;
    logic cal_start;
    logic oe_out;
  } osr_core_t;

  osr_link_t l_reg;
  osr_link_t l_next;
  osr_core_t c_reg;
  osr_core_t c_next;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic osr_core_t cfg_defaults(input osr_core_t cur);
    osr_core_t r;
    r = cur;
    r.page = osr_pkg::RST_PAGE;
    r.oe_ovr = osr_pkg::RST_OE;
    r.hs = osr_pkg::RST_HS;
    r.lsd = osr_pkg::RST_LSD;
    r.fb = osr_pkg::RST_FB;
    r.skip = osr_pkg::RST_SKIP;
    r.ffo_stage = osr_pkg::RST_FFO[15:0];
    r.ffo = osr_pkg::RST_FFO;
    return r;
  endfunction : cfg_defaults

  function automatic logic [7:0] rd_byte(input osr_core_t c, input logic [9:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a[7:0] == osr_pkg::PTR_PAGE)
      r = {6'h00, c.page};
    else
      unique case (a)
        osr_pkg::A_IDENT: r = DEVICE_ID;
        osr_pkg::A_OE: r = {7'h00, c.oe_ovr};
        osr_pkg::A_HS_LO: r = c.hs[7:0];
        osr_pkg::A_HS_HI: r = {1'b0, c.lsd, 1'b0, c.hs[10:8]};
        osr_pkg::A_FB0: r = c.fb[7:0];
        osr_pkg::A_FB1: r = c.fb[15:8];
        osr_pkg::A_FB2: r = c.fb[23:16];
        osr_pkg::A_FB3: r = c.fb[31:24];
        osr_pkg::A_FB4: r = c.fb[39:32];
        osr_pkg::A_FB5: r = {5'h00, c.fb[42:40]};
        osr_pkg::A_CAL: r = {c.skip, osr_pkg::CAL_RSVD_RD[6:0]};
        osr_pkg::A_FFO0: r = c.ffo[7:0];
        osr_pkg::A_FFO1: r = c.ffo[15:8];
        osr_pkg::A_FFO2: r = c.ffo[23:16];
        default: r = 8'h00;
      endcase
    return r;
  endfunction : rd_byte

  function automatic logic hs_legal(input logic [10:0] v);
    return (v >= osr_pkg::HS_MIN && v <= osr_pkg::HS_ODD_MAX) ||
           (v > osr_pkg::HS_ODD_MAX && v <= osr_pkg::HS_MAX && !v[0]);
  endfunction : hs_legal

  function automatic logic [5:0] pow2_ratio(input logic [2:0] code);
    return (code >= osr_pkg::LSD_MAX_CODE) ? osr_pkg::RATIO_MAX : (6'h01 << code);
  endfunction : pow2_ratio

  // ----------------------------------------------------------------
  // serial front end (link clock)
  // ----------------------------------------------------------------
  logic l_rise;
  logic l_fall;
  logic l_start;
  logic l_stop;

  assign l_rise = l_reg.scl_s2 && !l_reg.scl_d;
  assign l_fall = !l_reg.scl_s2 && l_reg.scl_d;
  assign l_start = l_reg.scl_s2 && l_reg.scl_d && l_reg.sda_d && !l_reg.sda_s2;
  assign l_stop = l_reg.scl_s2 && l_reg.scl_d && !l_reg.sda_d && l_reg.sda_s2;

  always_comb
  begin
    l_next = l_reg;
    l_next.rst_s1 = sys_rst_in;
    l_next.rst_s2 = l_reg.rst_s1;
    l_next.scl_s1 = scl_in;
    l_next.scl_s2 = l_reg.scl_s1;
    l_next.sda_s1 = sda_in;
    l_next.sda_s2 = l_reg.sda_s1;
    l_next.scl_d = l_reg.scl_s2;
    l_next.sda_d = l_reg.sda_s2;
    l_next.ack_s1 = c_reg.ack_tgl;
    l_next.ack_s2 = l_reg.ack_s1;
    if (l_start)
    begin
      l_next.state = LS_ADDR;
      l_next.bitcnt = 4'h0;
      l_next.sda_drv = 1'b0;
      l_next.scl_hold = 1'b0;
    end
    else if (l_stop)
    begin
      l_next.state = LS_IDLE;
      l_next.sda_drv = 1'b0;
      l_next.scl_hold = 1'b0;
    end
    else
      unique case (l_reg.state)
        LS_IDLE: l_next.sda_drv = 1'b0;
        LS_ADDR, LS_RX:
        begin
          if (l_rise)
          begin
            l_next.shreg = {l_reg.shreg[6:0], l_reg.sda_s2};
            l_next.bitcnt = l_reg.bitcnt + 4'h1;
          end
          else if (l_fall && l_reg.bitcnt == osr_pkg::BYTE_BITS)
          begin
            l_next.bitcnt = 4'h0;
            if (l_reg.state == LS_ADDR)
            begin
              l_next.rw = l_reg.shreg[0];
              l_next.sda_drv = (l_reg.shreg[7:1] == SLAVE_ADDR);
              l_next.state = (l_reg.shreg[7:1] == SLAVE_ADDR) ? LS_AACK : LS_IDLE;
            end
            else
            begin
              l_next.sda_drv = 1'b1;
              l_next.state = LS_RXACK;
              l_next.first_byte = 1'b0;
              if (l_reg.first_byte)
                l_next.ptr = l_reg.shreg;
              else
              begin
                l_next.req_we = 1'b1;
                l_next.req_ptr = l_reg.ptr;
                l_next.req_wd = l_reg.shreg;
                l_next.req_tgl = !l_reg.req_tgl;
                l_next.ptr = l_reg.ptr + 8'h01;
              end
            end
          end
        end
        LS_AACK:
          if (l_fall)
          begin
            l_next.sda_drv = 1'b0;
            l_next.first_byte = 1'b1;
            l_next.state = LS_RX;
            if (l_reg.rw)
            begin
              l_next.req_we = 1'b0;
              l_next.req_ptr = l_reg.ptr;
              l_next.req_tgl = !l_reg.req_tgl;
              l_next.scl_hold = 1'b1;
              l_next.state = LS_RDREQ;
            end
          end
        LS_RXACK:
          if (l_fall)
          begin
            l_next.sda_drv = 1'b0;
            l_next.state = LS_RX;
          end
        LS_RDREQ:
          // scl held low until the core answers; bit 7 is driven in the same cycle scl is released
          if (l_reg.ack_s2 != l_reg.ack_seen)
          begin
            l_next.ack_seen = l_reg.ack_s2;
            l_next.sda_drv = !c_reg.rdata[7];
            l_next.rbyte = {c_reg.rdata[6:0], 1'b0};
            l_next.ptr = l_reg.ptr + 8'h01;
            l_next.bitcnt = 4'h1;
            l_next.scl_hold = 1'b0;
            l_next.state = LS_TX;
          end
        LS_TX:
          if (l_fall)
          begin
            if (l_reg.bitcnt == osr_pkg::BYTE_BITS)
            begin
              l_next.sda_drv = 1'b0;
              l_next.state = LS_TXACK;
            end
            else
            begin
              l_next.sda_drv = !l_reg.rbyte[7];
              l_next.rbyte = {l_reg.rbyte[6:0], 1'b0};
              l_next.bitcnt = l_reg.bitcnt + 4'h1;
            end
          end
        LS_TXACK:
          if (l_rise)
            l_next.shreg[0] = l_reg.sda_s2;
          else if (l_fall)
          begin
            l_next.state = LS_IDLE;
            if (!l_reg.shreg[0])
            begin
              l_next.req_we = 1'b0;
              l_next.req_ptr = l_reg.ptr;
              l_next.req_tgl = !l_reg.req_tgl;
              l_next.scl_hold = 1'b1;
              l_next.state = LS_RDREQ;
            end
          end
      endcase
    if (l_reg.rst_s2)
    begin
      l_next = '0;
      l_next.rst_s1 = sys_rst_in;
      l_next.rst_s2 = l_reg.rst_s1;
      l_next.state = LS_IDLE;
      // keep tracking the wires so no false edge follows release
      l_next.scl_s1 = scl_in;
      l_next.scl_s2 = l_reg.scl_s1;
      l_next.scl_d = l_reg.scl_s2;
      l_next.sda_s1 = sda_in;
      l_next.sda_s2 = l_reg.sda_s1;
      l_next.sda_d = l_reg.sda_s2;
    end
  end

  always_ff @(posedge link_clock_in)
    l_reg <= l_next;

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = l_reg.scl_hold;
  assign sda_oe_out = l_reg.sda_drv;

  // ----------------------------------------------------------------
  // register file (core clock)
  // ----------------------------------------------------------------
  logic svc;
  logic [9:0] svc_addr;
  logic [7:0] wd;

  assign svc = c_reg.req_s2 != c_reg.req_seen;
  // pointer 255 reaches the page register from any page
  assign svc_addr = {c_reg.page, l_reg.req_ptr};
  assign wd = l_reg.req_wd;

  always_comb
  begin
    c_next = c_reg;
    c_next.en_s1 = active_low_enable_pin_n_in;
    c_next.en_s2 = c_reg.en_s1;
    c_next.req_s1 = l_reg.req_tgl;
    c_next.req_s2 = c_reg.req_s1;
    c_next.dev_rst = 1'b0;
    c_next.cal_start = 1'b0;
    c_next.ffo_upd = 1'b0;
    c_next.oe_out = c_reg.oe_ovr && !c_reg.en_s2;
    if (svc)
    begin
      c_next.req_seen = c_reg.req_s2;
      // only reads are answered; a write answer would release the next read stretch early
      if (!l_reg.req_we)
        c_next.ack_tgl = !c_reg.ack_tgl;
      c_next.rdata = rd_byte(c_reg, svc_addr);
      if (l_reg.req_we)
      begin
        if (l_reg.req_ptr == osr_pkg::PTR_PAGE)
          c_next.page = wd[1:0];
        else
          // ident and unmapped addresses fall through untouched
          unique case (svc_addr)
            osr_pkg::A_CTRL:
              if (wd[osr_pkg::CTRL_RST_BIT])
              begin
                c_next = cfg_defaults(c_next);
                c_next.dev_rst = 1'b1;
              end
              else if (wd[osr_pkg::CTRL_CAL_BIT])
                c_next.cal_start = !c_reg.skip;
            osr_pkg::A_OE: c_next.oe_ovr = wd[osr_pkg::OE_BIT];
            osr_pkg::A_HS_LO: c_next.hs[7:0] = wd;
            osr_pkg::A_HS_HI:
            begin
              c_next.hs[10:8] = wd[2:0];
              c_next.lsd = wd[osr_pkg::LSD_LSB +: 3];
            end
            osr_pkg::A_FB0: c_next.fb[7:0] = wd;
            osr_pkg::A_FB1: c_next.fb[15:8] = wd;
            osr_pkg::A_FB2: c_next.fb[23:16] = wd;
            osr_pkg::A_FB3: c_next.fb[31:24] = wd;
            osr_pkg::A_FB4: c_next.fb[39:32] = wd;
            osr_pkg::A_FB5: c_next.fb[42:40] = wd[2:0];
            osr_pkg::A_CAL: c_next.skip = wd[osr_pkg::CAL_SKIP_BIT];
            osr_pkg::A_FFO0: c_next.ffo_stage[7:0] = wd;
            osr_pkg::A_FFO1: c_next.ffo_stage[15:8] = wd;
            osr_pkg::A_FFO2:
            begin
              c_next.ffo = {wd, c_reg.ffo_stage};
              c_next.ffo_upd = 1'b1;
            end
            default: c_next.page = c_reg.page;
          endcase
      end
    end
    if (sys_rst_in)
    begin
      c_next = cfg_defaults('0);
    end
  end

  always_ff @(posedge clock_in)
    c_reg <= c_next;

  assign clock_output_enable_out = c_reg.oe_out;
  assign device_reset_out = c_reg.dev_rst;
  assign calibration_start_out = c_reg.cal_start;
  assign high_speed_divider_out = c_reg.hs;
  assign high_speed_divider_valid_out = hs_legal(c_reg.hs);
  assign power_of_two_divider_out = c_reg.lsd;
  assign power_of_two_ratio_out = pow2_ratio(c_reg.lsd);
  assign feedback_divider_out = c_reg.fb;
  assign feedback_integer_valid_out = c_reg.fb[42:32] >= osr_pkg::FB_INT_MIN &&
                                      c_reg.fb[42:32] <= osr_pkg::FB_INT_MAX;
  assign fine_frequency_offset_out = c_reg.ffo;
  assign fine_offset_update_out = c_reg.ffo_upd;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_write(logic [9:0] a);
    svc && l_reg.req_we && svc_addr == a && l_reg.req_ptr != osr_pkg::PTR_PAGE;
  endsequence

  sequence s_read(logic [9:0] a);
    svc && !l_reg.req_we && svc_addr == a;
  endsequence

  a_ident_fixed: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_read(osr_pkg::A_IDENT) |=> c_reg.rdata == DEVICE_ID)
    else $error("ident read returned wrong value");

  a_reset_self_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    device_reset_out |-> high_speed_divider_out == osr_pkg::RST_HS ##1 !device_reset_out)
    else $error("device reset not applied or not self clearing");

  a_cal_one_pulse: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_write(osr_pkg::A_CTRL) ##0 (wd[osr_pkg::CTRL_CAL_BIT] && !wd[osr_pkg::CTRL_RST_BIT] && !c_reg.skip)
    |=> calibration_start_out ##1 !calibration_start_out)
    else $error("calibration trigger did not pulse once");

  a_oe_override: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !c_reg.oe_ovr |=> !clock_output_enable_out)
    else $error("output enabled while override is clear");

  a_hs_odd_limit: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (high_speed_divider_out == 11'h023) |-> !high_speed_divider_valid_out)
    else $error("odd divider above 33 flagged legal");

  a_pow2_clip: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    power_of_two_divider_out > osr_pkg::LSD_MAX_CODE |-> power_of_two_ratio_out == osr_pkg::RATIO_MAX)
    else $error("codes 6 and 7 must divide by 32");

  a_fb_top_byte: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_write(osr_pkg::A_FB5) |=> feedback_divider_out[42:40] == $past(wd[2:0]))
    else $error("feedback divider top bits not stored");

  a_cal_skipped: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    c_reg.skip && !svc |=> !calibration_start_out)
    else $error("calibration started while skip is set");

  a_offset_commit: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $changed(fine_frequency_offset_out) |-> fine_offset_update_out || device_reset_out)
    else $error("fine offset changed without msb write");

  a_page_write: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    svc && l_reg.req_we && l_reg.req_ptr == osr_pkg::PTR_PAGE |=> c_reg.page == $past(wd[1:0]))
    else $error("page register not updated");

  a_ident_ro: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    s_write(osr_pkg::A_IDENT) |=> $stable(feedback_divider_out) && $stable(high_speed_divider_out))
    else $error("write to read-only address changed state");

  a_stretch_bound: assert property (@(posedge link_clock_in) disable iff (l_reg.rst_s2)
    $rose(l_reg.scl_hold) |-> ##[1:16] !l_reg.scl_hold)
    else $error("clock stretch exceeded bound");

endmodule : osr_regs

`default_nettype wire

/* File: bench/osr_i2c_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// i2c host on open-drain wires, timed by core clock
// ------------------------------------------------
module osr_i2c_host #(
  parameter int QTR = 12,
  parameter logic [6:0] ADDR = 7'h55
) (
  // timing clock
  input wire logic clock_in,
  // resolved wire levels
  input wire logic scl_in,
  input wire logic sda_in,
  // pull-downs, high = line held low
  output logic scl_low_out,
  output logic sda_low_out
);
  initial
  begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  task automatic qtr(input int n);
    repeat (n * QTR) @(posedge clock_in);
  endtask : qtr

  // two quarters of setup so a late stretch is seen before release
  task automatic bit_io(input logic b, output logic s);
    int k;
    sda_low_out <= ~b;
    qtr(2);
    scl_low_out <= 1'b0;
    for (k = 0; k < 400 && scl_in !== 1'b1; k++) @(posedge clock_in);
    qtr(1);
    s = sda_in;
    qtr(1);
    scl_low_out <= 1'b1;
    qtr(1);
  endtask : bit_io

  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, nak);
  endtask : xfer

  task automatic start();
    sda_low_out <= 1'b1;
    qtr(1);
    scl_low_out <= 1'b1;
    qtr(1);
  endtask : start

  task automatic stop();
    sda_low_out <= 1'b1;
    qtr(1);
    scl_low_out <= 1'b0;
    qtr(1);
    sda_low_out <= 1'b0;
    qtr(2);
  endtask : stop

  // one byte per transaction; ok means every byte was acked
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic n0, n1, n2;
    start();
    xfer({ADDR, 1'b0}, 1'b1, x, n0);
    xfer(p, 1'b1, x, n1);
    xfer(d, 1'b1, x, n2);
    stop();
    ok = ~(n0 | n1 | n2);
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [7:0] q, output logic ok);
    logic [7:0] x;
    logic n0, n1, n2, n3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, x, n0);
    xfer(p, 1'b1, x, n1);
    stop();
    start();
    xfer({ADDR, 1'b1}, 1'b1, x, n2);
    xfer(8'hFF, 1'b1, q, n3);
    stop();
    ok = ~(n0 | n1 | n2);
  endtask : rd
endmodule : osr_i2c_host
`default_nettype wire

/* File: bench/osr_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module osr_regs_test;
  // ----------------------------------------
  // clocks, wires and hookup
  // ----------------------------------------
  logic clock_in = 1'b0;
  logic link_clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pin_n = 1'b0;
  logic scl_low, sda_low, scl_oe, sda_oe, oe_o, dev_rst, cal, hs_ok, fb_ok, ffo_up, nak;
  logic [10:0] hs;
  logic [2:0] lsd, hi;
  logic [5:0] ratio;
  logic [42:0] fb;
  logic [23:0] ffo;
  logic [7:0] q, lo;
  logic [7:0] los [8] = '{8'h04, 8'h05, 8'h21, 8'h22, 8'h23, 8'hFF, 8'hFE, 8'hFF};
  logic [47:0] fbv = 48'hFF_FD_89_AB_CD_EF;
  int err_total = 0;
  int n_tests = 0;
  int n_cal = 0;
  int n_rst = 0;
  int n_up = 0;
  wire scl_w = ~(scl_low | scl_oe);
  wire sda_w = ~(sda_low | sda_oe);

  // type code value is arbitrary
  osr_regs #(.DEVICE_ID(8'h3C)) i_osr_regs (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .link_clock_in(link_clock_in), .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w),
    .sda_out(), .sda_oe_out(sda_oe), .active_low_enable_pin_n_in(pin_n), .clock_output_enable_out(oe_o),
    .device_reset_out(dev_rst), .calibration_start_out(cal), .high_speed_divider_out(hs),
    .high_speed_divider_valid_out(hs_ok), .power_of_two_divider_out(lsd), .power_of_two_ratio_out(ratio),
    .feedback_divider_out(fb), .feedback_integer_valid_out(fb_ok), .fine_frequency_offset_out(ffo),
    .fine_offset_update_out(ffo_up));
  osr_i2c_host i_osr_i2c_host (.clock_in(clock_in), .scl_in(scl_w), .sda_in(sda_w),
    .scl_low_out(scl_low), .sda_low_out(sda_low));

  initial forever #12.5 clock_in = ~clock_in;
  initial
  begin
    #7;
    forever #62.5 link_clock_in = ~link_clock_in;
  end

  always @(posedge clock_in)
  begin
    if (cal === 1'b1) n_cal <= n_cal + 1;
    if (dev_rst === 1'b1) n_rst <= n_rst + 1;
    if (ffo_up === 1'b1) n_up <= n_up + 1;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hs_legal(input logic [10:0] v);
    return (v >= 11'h005 && v <= 11'h021) || (v >= 11'h022 && v <= 11'h7FE && !v[0]);
  endfunction : hs_legal

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic ok;
    i_osr_i2c_host.wr(p, d, ok);
    chk(ok, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic ok;
    logic [7:0] got;
    i_osr_i2c_host.rd(p, got, ok);
    chk(ok, 1'b1);
    chk(got, e);
  endtask : rd

  task automatic test_done();
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    // held past four link edges so the link side resets too
    repeat (24) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (40) @(posedge clock_in);
    chk({hs, fb, ffo}, {11'h054, 43'h064_0000_0000, 24'h00_0000});
    chk({oe_o, ratio, hs_ok, fb_ok}, {1'b1, 6'h01, 1'b1, 1'b1});
    rd(8'h00, 8'h3C);
    rd(8'h45, 8'h01);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h3C);
    i_osr_i2c_host.start();
    i_osr_i2c_host.xfer(8'h44, 1'b1, q, nak);
    i_osr_i2c_host.stop();
    chk(nak, 1'b1);
    pin_n <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk(oe_o, 1'b0);
    pin_n <= 1'b0;
    wr(8'h11, 8'h00);
    chk(oe_o, 1'b0);
    wr(8'h11, 8'hFF);
    chk(oe_o, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      lo = los[i];
      hi = i > 5 ? 3'h7 : 3'h0;
      wr(8'h17, lo);
      wr(8'h18, {1'b1, 3'(i), 1'b1, hi});
      chk({hs, hs_ok}, {hi, lo, hs_legal({hi, lo})});
      chk({lsd, ratio}, {3'(i), i > 5 ? 6'h20 : 6'h01 << i});
    end
    for (int k = 0; k < 6; k++) wr(8'h1A + 8'(k), fbv[8 * k +: 8]);
    chk({fb, fb_ok}, {11'h7FD, 32'h89AB_CDEF, 1'b1});
    wr(8'h1E, 8'h3C);
    wr(8'h1F, 8'h00);
    chk({fb, fb_ok}, {11'h03C, 32'h89AB_CDEF, 1'b1});
    wr(8'hE7, 8'h17);
    wr(8'hE8, 8'h77);
    chk({ffo, 8'(n_up)}, {24'h00_0000, 8'h00});
    rd(8'hE7, 8'h00);
    wr(8'hE9, 8'h83);
    chk({ffo, 8'(n_up)}, {24'h83_7717, 8'h01});
    wr(8'h07, 8'h08);
    chk(n_cal, 1);
    rd(8'h07, 8'h00);
    wr(8'h45, 8'h80);
    wr(8'h07, 8'h08);
    chk(n_cal, 1);
    wr(8'hFF, 8'h01);
    rd(8'h00, 8'h00);
    rd(8'hFF, 8'h01);
    wr(8'hFF, 8'h00);
    wr(8'h07, 8'h80);
    chk({8'(n_rst), 8'(n_cal)}, {8'h01, 8'h01});
    chk({hs, fb, ffo}, {11'h054, 43'h064_0000_0000, 24'h00_0000});
    rd(8'h00, 8'h3C);
    wr(8'h07, 8'h08);
    chk(n_cal, 2);
    test_done();
  end

  initial
  begin
    repeat (95000) @(posedge clock_in);
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end
endmodule : osr_regs_test
`default_nettype wire
